// file: dmaseq_top.sv
`timescale 1ns/10ps
// Summary of operation
// - With auto reload on, reload working registers after a block and continue.
// - Reload registers may change anytime; element reload is also used at each frame end, the rest only at block end.
// - Reload values stay in place and are reused for every later block.
// - Reload-select bit 14: 0 all channels use set 0, 1 own set.
// - 8-bit frame counter drops on last transfer of a frame; zero is one frame.
// - After the last frame, with auto reload, frame counter takes reload value.
// - 16-bit element counter drops per element; ffff gives 65536 elements.
// - With auto reload, element counter takes reload value after the last frame.
// - Doubleword: two 16-bit transfers per element, addresses step after each.
// - Source and destination index selects choose element and frame steps.
// - All but the frame's last transfer add the selected element step.
// - The frame's last transfer adds the selected frame step instead.
// - Interrupt enable low means no interrupt, whatever the timing bit says.
// - Auto-buffering: timing 0 full buffer only; 1 half and full buffer.
// - Multiframe: timing 0 block end only; 1 every frame end and block end.
// - 4-bit sync field picks the trigger event; zero means free running.
// - Each of the six channels has its own interrupt request.
// - After reset, shared lines carry serial port interrupts only.
// - 2-bit select routes channels or serial ports onto shared lines.
// - Same-priority channels are served round robin; priority per channel.
module dmaseq_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Synchronisation events
  input  wire logic        ser0_rx_evt,
  input  wire logic        ser0_tx_evt,
  input  wire logic        ser2_rx_evt,
  input  wire logic        ser2_tx_evt,
  input  wire logic        ser1_rx_evt,
  input  wire logic        ser1_tx_evt,
  input  wire logic        uart_evt,
  input  wire logic        timer0_evt,
  input  wire logic        ext_int3,
  input  wire logic        timer1_evt,
  // Serial port interrupts sharing CPU lines
  input  wire logic        serial2_receive_interrupt,
  input  wire logic        serial2_transmit_interrupt,
  input  wire logic        serial1_receive_interrupt,
  input  wire logic        serial1_transmit_interrupt,
  // Transfer port
  output logic             xfer_req,
  output logic [15:0]      xfer_src,
  output logic [15:0]      xfer_dst,
  input  wire logic        xfer_ack,
  // Interrupts: per channel, and shared CPU lines 6, 7, 10, 11
  output logic [5:0]       chan_irq,
  output logic [3:0]       cpu_int_shared
);
  import dmaseq_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  typedef enum logic [0:0] {DS_IDLE = 1'b0, DS_BUSY = 1'b1} dmaseq_fsm_t;

  typedef struct packed {
    logic [5:0][15:0] src, dst, elem, rsrc, rdst, relem, mode;
    logic [5:0][7:0]  frm, rfrm;
    logic [5:0][3:0]  syn;
    logic [1:0][15:0] estep, fstep;
    logic [15:0]      prec;
    logic [5:0]       pend, irq;
    logic [3:0]       line;
    dmaseq_fsm_t      fsm;
    logic [2:0]       cur, rr;
    logic             half, xreq;
    logic [15:0]      xsrc, xdst;
    logic             wpend;
    logic [2:0]       wch;
    logic [3:0]       wreg;
    logic             ready, resp;
    logic [31:0]      rdata;
  } dmaseq_state_t;

  dmaseq_state_t st_q;
  dmaseq_state_t st_d;

  logic [NEVT-1:0] evt_rise;
  logic [15:0]     evt_vec;

  dmaseq_pin_sync #(.W(NEVT)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin_in  ({timer1_evt, ext_int3, timer0_evt, uart_evt, ser1_tx_evt,
               ser1_rx_evt, ser2_tx_evt, ser2_rx_evt, ser0_tx_evt, ser0_rx_evt}),
    .rise    (evt_rise)
  );

  // Event index equals the sync code; reserved codes never fire
  assign evt_vec = {evt_rise[9:7], 5'h00, evt_rise[6:0], 1'b0};

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [15:0] step_f(input logic [2:0] sel, input logic last,
                                         input logic [1:0][15:0] es, input logic [1:0][15:0] fs);
    case (sel)
      IX_INC:  step_f = 16'h0001;
      IX_DEC:  step_f = 16'hffff;
      IX_A:    step_f = last ? fs[0] : es[0];
      IX_B:    step_f = last ? fs[1] : es[1];
      default: step_f = 16'h0000;
    endcase
  endfunction

  // Returns {found, channel}, searching from the channel after the last winner
  function automatic logic [3:0] pick_f(input logic [5:0] req, input logic [2:0] rr);
    int k;
    pick_f = 4'h0;
    for (int i = 6; i >= 1; i--) begin
      k = (int'(rr) + i) % NCH;
      if (req[k]) begin
        pick_f = {1'b1, 3'(k)};
      end
    end
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  logic [2:0]  c;
  logic [2:0]  rs;
  logic [15:0] cm;
  logic [5:0]  rdy;
  logic [3:0]  ph;
  logic [3:0]  pl;
  logic        lastel, lastx, fire, wr;
  logic [15:0] wd;

  always_comb begin
    st_d     = st_q;
    st_d.irq = '0;
    c        = st_q.cur;
    cm       = st_q.mode[c];
    rs       = st_q.prec[P_RLSEL] ? c : 3'h0;
    lastel   = (st_q.elem[c] == 16'h0000);
    lastx    = lastel && (!cm[M_DW] || st_q.half);
    fire     = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      rdy[i] = st_q.prec[i] && (st_q.syn[i] == SYN_NONE || st_q.pend[i]);
    end
    ph = pick_f(rdy & st_q.prec[P_PRIO +: 6], st_q.rr);
    pl = pick_f(rdy & ~st_q.prec[P_PRIO +: 6], st_q.rr);
    unique case (st_q.fsm)
      DS_IDLE: begin
        if (ph[3] || pl[3]) begin
          c              = ph[3] ? ph[2:0] : pl[2:0];
          st_d.cur       = c;
          st_d.rr        = c;
          st_d.pend[c]   = 1'b0;
          st_d.xreq      = 1'b1;
          st_d.xsrc      = st_q.src[c];
          st_d.xdst      = st_q.dst[c];
          st_d.fsm       = DS_BUSY;
        end
      end
      DS_BUSY: begin
        if (xfer_ack) begin
          st_d.xreq   = 1'b0;
          st_d.src[c] = st_q.src[c] + step_f(cm[M_SOURCE_INDEX_SELECT +: 3], lastx, st_q.estep, st_q.fstep);
          st_d.dst[c] = st_q.dst[c] + step_f(cm[M_DESTINATION_INDEX_SELECT +: 3], lastx, st_q.estep, st_q.fstep);
          if (cm[M_DW] && !st_q.half) begin
            // First half of a doubleword: second transfer at stepped addresses
            st_d.half = 1'b1;
            st_d.xreq = 1'b1;
            st_d.xsrc = st_d.src[c];
            st_d.xdst = st_d.dst[c];
          end else begin
            st_d.half = 1'b0;
            st_d.fsm  = DS_IDLE;
            if (cm[M_ABU]) begin
              // Circular buffer of relem+1 elements, runs until disabled
              if (lastel) begin
                st_d.elem[c] = st_q.relem[rs];
                fire         = 1'b1;
              end else begin
                st_d.elem[c] = st_q.elem[c] - 16'h0001;
                fire         = cm[M_ITM] && (st_q.elem[c] == (st_q.relem[rs] >> 1));
              end
            end else if (!lastel) begin
              st_d.elem[c] = st_q.elem[c] - 16'h0001;
            end else if (st_q.frm[c] != 8'h00) begin
              st_d.frm[c]  = st_q.frm[c] - 8'h01;
              st_d.elem[c] = st_q.relem[rs];
              fire         = cm[M_ITM];
            end else begin
              fire = 1'b1;
              if (cm[M_ARL]) begin
                // Reload source, destination and frame values are read only here, at the block boundary
                st_d.src[c]  = st_q.rsrc[rs];
                st_d.dst[c]  = st_q.rdst[rs];
                st_d.elem[c] = st_q.relem[rs];
                st_d.frm[c]  = st_q.rfrm[rs];
              end else begin
                st_d.prec[c] = 1'b0;
              end
            end
            st_d.irq[c] = fire && cm[M_IEN];
          end
        end
      end
    endcase
    // Sync events arm a channel; arming wins over the clear at pickup
    for (int i = 0; i < NCH; i++) begin
      if (st_q.syn[i] != SYN_NONE && evt_vec[st_q.syn[i]]) begin
        st_d.pend[i] = 1'b1;
      end
    end
    // Shared CPU lines; reserved select keeps the serial ports
    unique case (st_q.prec[P_ISEL +: 2])
      ISEL_ALL:  st_d.line = st_d.irq[3:0];
      ISEL_HALF: st_d.line = {st_d.irq[3:2], serial2_transmit_interrupt, serial2_receive_interrupt};
      default:   st_d.line = {serial1_transmit_interrupt, serial1_receive_interrupt,
                              serial2_transmit_interrupt, serial2_receive_interrupt};
    endcase
    // AHB data phase write; software wins over the engine in the same cycle
    wr = st_q.wpend;
    wd = hwdata[15:0];
    st_d.wpend = 1'b0;
    if (wr && st_q.wch == GLOBAL_CH) begin
      unique case (st_q.wreg)
        G_ESTEP_A: st_d.estep[0] = wd;
        G_ESTEP_B: st_d.estep[1] = wd;
        G_FSTEP_A: st_d.fstep[0] = wd;
        G_FSTEP_B: st_d.fstep[1] = wd;
        G_PREC:    st_d.prec     = wd;
        default:   st_d.prec     = st_d.prec;
      endcase
    end else if (wr && st_q.wch < GLOBAL_CH) begin
      unique case (st_q.wreg)
        R_SRC:    st_d.src[st_q.wch]   = wd;
        R_DST:    st_d.dst[st_q.wch]   = wd;
        R_ELEM:   st_d.elem[st_q.wch]  = wd;
        R_SYNFRM: begin
          st_d.syn[st_q.wch] = wd[SF_SYN +: 4];
          st_d.frm[st_q.wch] = wd[7:0];
        end
        R_MODE:   st_d.mode[st_q.wch]  = wd;
        R_RSRC:   st_d.rsrc[st_q.wch]  = wd;
        R_RDST:   st_d.rdst[st_q.wch]  = wd;
        R_RELEM:  st_d.relem[st_q.wch] = wd;
        R_RFRM:   st_d.rfrm[st_q.wch]  = wd[7:0];
        default:  st_d.src[st_q.wch]   = st_d.src[st_q.wch];
      endcase
    end
    // AHB address phase; read data comes from the updated image
    if (hsel && hready && htrans == HTRANS_NSQ) begin
      st_d.wpend = hwrite;
      st_d.wch   = haddr[8:6];
      st_d.wreg  = haddr[5:2];
      if (!hwrite) begin
        st_d.rdata = 32'h0000_0000;
        if (haddr[8:6] == GLOBAL_CH) begin
          unique case (haddr[5:2])
            G_ESTEP_A: st_d.rdata[15:0] = st_d.estep[0];
            G_ESTEP_B: st_d.rdata[15:0] = st_d.estep[1];
            G_FSTEP_A: st_d.rdata[15:0] = st_d.fstep[0];
            G_FSTEP_B: st_d.rdata[15:0] = st_d.fstep[1];
            G_PREC:    st_d.rdata[15:0] = st_d.prec;
            default:   st_d.rdata       = 32'h0000_0000;
          endcase
        end else if (haddr[8:6] < GLOBAL_CH) begin
          unique case (haddr[5:2])
            R_SRC:    st_d.rdata[15:0] = st_d.src[haddr[8:6]];
            R_DST:    st_d.rdata[15:0] = st_d.dst[haddr[8:6]];
            R_ELEM:   st_d.rdata[15:0] = st_d.elem[haddr[8:6]];
            R_SYNFRM: st_d.rdata[15:0] = {st_d.syn[haddr[8:6]], 4'h0, st_d.frm[haddr[8:6]]};
            R_MODE:   st_d.rdata[15:0] = st_d.mode[haddr[8:6]];
            R_RSRC:   st_d.rdata[15:0] = st_d.rsrc[haddr[8:6]];
            R_RDST:   st_d.rdata[15:0] = st_d.rdst[haddr[8:6]];
            R_RELEM:  st_d.rdata[15:0] = st_d.relem[haddr[8:6]];
            R_RFRM:   st_d.rdata[7:0]  = st_d.rfrm[haddr[8:6]];
            default:  st_d.rdata       = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= '0;
      st_q.prec  <= PREC_RST;
      st_q.ready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout      = st_q.ready;
  assign hrdata         = st_q.rdata;
  assign hresp          = st_q.resp;
  assign xfer_req       = st_q.xreq;
  assign xfer_src       = st_q.xsrc;
  assign xfer_dst       = st_q.xdst;
  assign chan_irq       = st_q.irq;
  assign cpu_int_shared = st_q.line;

  // ************************************************************
  // Assertions
  // ************************************************************
  logic [15:0] a_cm;
  logic [2:0]  a_rs;
  logic        a_done, a_blk, a_ack;
  assign a_cm   = st_q.mode[st_q.cur];
  assign a_rs   = st_q.prec[P_RLSEL] ? st_q.cur : 3'h0;
  assign a_ack  = st_q.fsm == DS_BUSY && xfer_ack && !st_q.wpend;
  assign a_done = a_ack && (!a_cm[M_DW] || st_q.half) && !a_cm[M_ABU];
  assign a_blk  = a_done && st_q.elem[st_q.cur] == 16'h0000 && st_q.frm[st_q.cur] == 8'h00;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_irq_gate;
    st_q.irq != 6'h00 |-> st_q.irq == (6'h01 << st_q.cur) && a_cm[M_IEN];
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");

  property p_elem_dec;
    a_done && st_q.elem[st_q.cur] != 16'h0000 |=>
      st_q.elem[st_q.cur] == $past(st_q.elem[st_q.cur]) - 16'h0001;
  endproperty
  a_elem_dec: assert property (p_elem_dec) else $error("element count not decremented");

  property p_frm_dec;
    a_done && st_q.elem[st_q.cur] == 16'h0000 && st_q.frm[st_q.cur] != 8'h00 |=>
      st_q.frm[st_q.cur] == $past(st_q.frm[st_q.cur]) - 8'h01;
  endproperty
  a_frm_dec: assert property (p_frm_dec) else $error("frame count not decremented");

  property p_frm_reload;
    a_blk && a_cm[M_ARL] |=> st_q.frm[st_q.cur] == $past(st_q.rfrm[a_rs]);
  endproperty
  a_frm_reload: assert property (p_frm_reload) else $error("frame reload wrong");

  property p_elem_reload;
    a_blk && a_cm[M_ARL] |=> st_q.elem[st_q.cur] == $past(st_q.relem[a_rs]) && st_q.prec[st_q.cur];
  endproperty
  a_elem_reload: assert property (p_elem_reload) else $error("element reload wrong");

  property p_stop;
    a_blk && !a_cm[M_ARL] |=> !st_q.prec[st_q.cur] ##1 !(xfer_req && st_q.cur == $past(st_q.cur, 2));
  endproperty
  a_stop: assert property (p_stop) else $error("channel kept running");

  property p_dw;
    a_ack && a_cm[M_DW] && !st_q.half |=> xfer_req && st_q.half && xfer_src == st_q.src[st_q.cur];
  endproperty
  a_dw: assert property (p_dw) else $error("second half missing");

  property p_estep;
    a_ack && a_cm[M_SOURCE_INDEX_SELECT +: 3] == IX_A && st_q.elem[st_q.cur] != 16'h0000 |=>
      st_q.src[st_q.cur] == $past(st_q.src[st_q.cur]) + $past(st_q.estep[0]);
  endproperty
  a_estep: assert property (p_estep) else $error("element step wrong");

  property p_fstep;
    a_done && a_cm[M_DESTINATION_INDEX_SELECT +: 3] == IX_B && st_q.elem[st_q.cur] == 16'h0000 && st_q.frm[st_q.cur] != 8'h00 |=>
      st_q.dst[st_q.cur] == $past(st_q.dst[st_q.cur]) + $past(st_q.fstep[1]);
  endproperty
  a_fstep: assert property (p_fstep) else $error("frame step wrong");

  property p_line_ser;
    reset_n && st_q.prec[P_ISEL +: 2] == ISEL_SER && !st_q.wpend |=>
      st_q.line == {$past(serial1_transmit_interrupt), $past(serial1_receive_interrupt),
                    $past(serial2_transmit_interrupt), $past(serial2_receive_interrupt)};
  endproperty
  a_line_ser: assert property (p_line_ser) else $error("shared line not serial");

  property p_arm;
    st_q.syn[0] != SYN_NONE && evt_vec[st_q.syn[0]] |=> st_q.pend[0];
  endproperty
  a_arm: assert property (p_arm) else $error("sync event lost");

  c_dw:   cover property (a_ack && a_cm[M_DW] && st_q.half);
  c_auto: cover property (a_blk && a_cm[M_ARL]);
  c_abu:  cover property (st_q.irq != 6'h00 && a_cm[M_ABU] && a_cm[M_ITM]);
endmodule

// file: dmaseq_pkg.sv
package dmaseq_pkg;
  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int          NCH        = 6;
  localparam int          NEVT       = 10;
  // ************************************************************
  // Register map: word index haddr[8:2]; channel = haddr[8:6]
  // ************************************************************
  localparam logic [2:0]  GLOBAL_CH  = 3'h6;
  localparam logic [3:0]  R_SRC      = 4'h0;
  localparam logic [3:0]  R_DST      = 4'h1;
  localparam logic [3:0]  R_ELEM     = 4'h2;
  localparam logic [3:0]  R_SYNFRM   = 4'h3;
  localparam logic [3:0]  R_MODE     = 4'h4;
  localparam logic [3:0]  R_RSRC     = 4'h5;
  localparam logic [3:0]  R_RDST     = 4'h6;
  localparam logic [3:0]  R_RELEM    = 4'h7;
  localparam logic [3:0]  R_RFRM     = 4'h8;
  localparam logic [3:0]  G_ESTEP_A  = 4'h0;
  localparam logic [3:0]  G_ESTEP_B  = 4'h1;
  localparam logic [3:0]  G_FSTEP_A  = 4'h2;
  localparam logic [3:0]  G_FSTEP_B  = 4'h3;
  localparam logic [3:0]  G_PREC     = 4'h4;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int          M_ARL      = 15;
  localparam int          M_IEN      = 14;
  localparam int          M_ITM      = 13;
  localparam int          M_ABU      = 12;
  localparam int          M_SOURCE_INDEX_SELECT     = 8;
  localparam int          M_DW       = 7;
  localparam int          M_DESTINATION_INDEX_SELECT     = 2;
  localparam int          P_RLSEL    = 14;
  localparam int          P_PRIO     = 8;
  localparam int          P_ISEL     = 6;
  localparam int          SF_SYN     = 12;
  // ************************************************************
  // Codes and reset values
  // ************************************************************
  localparam logic [3:0]  SYN_NONE   = 4'h0;
  localparam logic [2:0]  IX_INC     = 3'h1;
  localparam logic [2:0]  IX_DEC     = 3'h2;
  localparam logic [2:0]  IX_A       = 3'h3;
  localparam logic [2:0]  IX_B       = 3'h4;
  localparam logic [1:0]  ISEL_SER   = 2'h0;
  localparam logic [1:0]  ISEL_HALF  = 2'h1;
  localparam logic [1:0]  ISEL_ALL   = 2'h2;
  localparam logic [15:0] PREC_RST   = 16'h0000;
  localparam logic [1:0]  HTRANS_NSQ = 2'h2;
endpackage

// file: dmaseq_pin_sync.sv
`timescale 1ns/10ps
module dmaseq_pin_sync #(
  parameter int W = dmaseq_pkg::NEVT
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Raw event levels and their rising-edge pulses
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] rise
);
  import dmaseq_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
    logic [W-1:0] pulse;
  } dmaseq_sync_t;

  dmaseq_sync_t q;
  dmaseq_sync_t d;

  always_comb begin
    d        = q;
    d.s1     = pin_in;
    d.s2     = q.s1;
    d.s3     = q.s2;
    // A level counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.stable[i] = q.s3[i];
      end
    end
    d.pulse  = d.stable & ~q.stable;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = q.pulse;
endmodule

// file: dmaseq_far_end.sv
`timescale 1ns/10ps
// ****
// Transfer port responder
// ****
module dmaseq_far_end (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Transfer port
  input  wire logic xfer_req,
  input  wire logic slow,
  output logic      xfer_ack
);
  logic [1:0] wait_q;
  // Acks only a standing request; a slow peer holds it off for three cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_q   <= 2'h0;
      xfer_ack <= 1'b0;
    end else if (xfer_req && !xfer_ack && (!slow || wait_q == 2'h3)) begin
      wait_q   <= 2'h0;
      xfer_ack <= 1'b1;
    end else begin
      wait_q   <= (xfer_req && !xfer_ack) ? wait_q + 2'h1 : 2'h0;
      xfer_ack <= 1'b0;
    end
  end
endmodule

// file: dma_channel_sequencing_tb_top.sv
`timescale 1ns/10ps
// ****
// Bench
// ****
module dma_channel_sequencing_tb_top;
  import dmaseq_pkg::*;
  logic        sys_clk, reset_n, hsel, hwrite, hready, hresp, xfer_req, xfer_ack, slow;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] xfer_src, xfer_dst;
  logic [5:0]  chan_irq;
  logic [3:0]  cpu_int_shared, ser_irq;
  logic [9:0]  evt;
  int          fails, check_count, irq_n, line_n, i;
  logic [15:0] src_q[$], dst_q[$], exp_s[$], exp_d[$];
  // Register rows: address, write value, readback; the last two are unmapped or cut to 16 bits
  logic [31:0] ra[9] = '{32'h180, 32'h184, 32'h188, 32'h18c, 32'h190, 32'h54, 32'h160, 32'hdc, 32'h1a0};
  logic [31:0] rw[9] = '{32'h4, 32'h8, 32'h10, 32'h20, 32'h4000, 32'h1234, 32'h55, 32'hffffbeef, 32'h1111};
  logic [31:0] rx[9] = '{32'h4, 32'h8, 32'h10, 32'h20, 32'h4000, 32'h1234, 32'h55, 32'hbeef, 32'h0};
  logic [3:0]  route[4] = '{4'hf, 4'h3, 4'h0, 4'hf};
  // Auto reload trail: one start block, then blocks of two one-element frames from the reload set
  logic [15:0] auto_s[6] = '{16'h100, 16'h300, 16'h301, 16'h300, 16'h301, 16'h500};

  dmaseq_top u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata),
    .hresp(hresp), .ser0_rx_evt(evt[0]), .ser0_tx_evt(evt[1]), .ser2_rx_evt(evt[2]), .ser2_tx_evt(evt[3]),
    .ser1_rx_evt(evt[4]), .ser1_tx_evt(evt[5]), .uart_evt(evt[6]), .timer0_evt(evt[7]), .ext_int3(evt[8]),
    .timer1_evt(evt[9]), .serial2_receive_interrupt(ser_irq[0]), .serial2_transmit_interrupt(ser_irq[1]),
    .serial1_receive_interrupt(ser_irq[2]), .serial1_transmit_interrupt(ser_irq[3]), .xfer_req(xfer_req),
    .xfer_src(xfer_src), .xfer_dst(xfer_dst), .xfer_ack(xfer_ack), .chan_irq(chan_irq),
    .cpu_int_shared(cpu_int_shared));
  dmaseq_far_end u_far (.sys_clk(sys_clk), .reset_n(reset_n), .xfer_req(xfer_req), .slow(slow),
    .xfer_ack(xfer_ack));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (xfer_req === 1'b1 && xfer_ack === 1'b1) begin
      src_q.push_back(xfer_src);
      dst_q.push_back(xfer_dst);
    end
    if (chan_irq[0] === 1'b1) irq_n++;
    if (cpu_int_shared[0] === 1'b1) line_n++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NSQ;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  // Runs channel 0 once; the address trail is built here from the step rules
  task automatic run(input int ne, input int nf, input int dw, input logic [15:0] mode,
                     input logic [15:0] se, input logic [15:0] sf, input logic [15:0] de,
                     input logic [15:0] df, input int nirq);
    logic [15:0] s, d;
    logic        last;
    s = 16'h0100;
    d = 16'h0200;
    src_q.delete();
    dst_q.delete();
    exp_s.delete();
    exp_d.delete();
    for (int f = 0; f < nf; f++) begin
      for (int e = 0; e < ne; e++) begin
        for (int h = 0; h <= dw; h++) begin
          exp_s.push_back(s);
          exp_d.push_back(d);
          last = (e == ne - 1) && (h == dw);
          s    = s + (last ? sf : se);
          d    = d + (last ? df : de);
        end
      end
    end
    bus(1'b1, 32'h0, 32'h0100);
    bus(1'b1, 32'h4, 32'h0200);
    bus(1'b1, 32'h8, 32'(ne - 1));
    bus(1'b1, 32'hc, 32'(nf - 1));
    bus(1'b1, 32'h1c, 32'(ne - 1));
    bus(1'b1, 32'h10, {16'h0, mode});
    irq_n  = 0;
    line_n = 0;
    bus(1'b1, 32'h190, 32'h0081);
    for (i = 0; i < 2000 && src_q.size() < exp_s.size(); i++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
    check(32'(src_q.size()), 32'(exp_s.size()));
    foreach (exp_s[k]) begin
      check({16'h0, src_q[k]}, {16'h0, exp_s[k]});
      check({16'h0, dst_q[k]}, {16'h0, exp_d[k]});
    end
    check(32'(irq_n), 32'(nirq));
    check(32'(line_n), 32'(nirq));
    bus(1'b0, 32'h0, 32'h0);
    check(rd, {16'h0, s});
  endtask

  task automatic test_done;
    if (fails == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #(20000 * 50);
    fails++;
    test_done;
  end

  initial begin
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    evt         = 10'h0;
    ser_irq     = 4'ha;
    slow        = 1'b0;
    reset_n     = 1'b0;
    fails       = 0;
    check_count = 0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check({28'h0, cpu_int_shared}, 32'ha);
    bus(1'b0, 32'h190, 32'h0);
    check(rd, {16'h0, PREC_RST});
    for (int r = 0; r < 9; r++) begin
      bus(1'b1, ra[r], rw[r]);
      bus(1'b0, ra[r], 32'h0);
      check(rd, rx[r]);
      check({31'h0, hresp}, 32'h0);
    end
    ser_irq <= 4'hf;
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, 32'h190, 32'(r) << 6);
      repeat (3) @(posedge sys_clk);
      check({28'h0, cpu_int_shared}, {28'h0, route[r]});
    end
    ser_irq <= 4'h0;
    run(3, 2, 0, 16'h6304, 16'h4, 16'h10, 16'h1, 16'h1, 2);
    slow <= 1'b1;
    run(2, 1, 1, 16'h4488, 16'h8, 16'h20, 16'hffff, 16'hffff, 1);
    run(1, 1, 0, 16'h2000, 16'h0, 16'h0, 16'h0, 16'h0, 0);
    // Timer 0 paced channel must sit still until its event arrives
    src_q.delete();
    bus(1'b1, 32'h8, 32'h0);
    bus(1'b1, 32'hc, 32'hd000);
    bus(1'b1, 32'h190, 32'h0001);
    repeat (20) @(posedge sys_clk);
    check(32'(src_q.size()), 32'h0);
    evt[7] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    evt[7] <= 1'b0;
    for (i = 0; i < 60 && src_q.size() == 0; i++) @(posedge sys_clk);
    check(32'(src_q.size()), 32'h1);
    // Auto reload; a reload source written mid-block may only show after the block end
    src_q.delete();
    bus(1'b1, 32'h0, 32'h0100);
    bus(1'b1, 32'hc, 32'h0);
    bus(1'b1, 32'h10, 32'h8100);
    bus(1'b1, 32'h14, 32'h0300);
    bus(1'b1, 32'h1c, 32'h0);
    bus(1'b1, 32'h20, 32'h1);
    bus(1'b1, 32'h190, 32'h0001);
    for (i = 0; i < 200 && src_q.size() < 4; i++) @(posedge sys_clk);
    bus(1'b1, 32'h14, 32'h0500);
    for (i = 0; i < 200 && src_q.size() < 6; i++) @(posedge sys_clk);
    bus(1'b1, 32'h190, 32'h0);
    foreach (auto_s[k]) begin
      check({16'h0, src_q[k]}, {16'h0, auto_s[k]});
    end
    test_done;
  end
endmodule
